/* verilog/mtb_defs.vh */
// register numbers, field masks and constants for the translation unit
`ifndef MTB_DEFS_VH
`define MTB_DEFS_VH
// coprocessor register numbers
`define MTB_REG_INDEX   5'h00
`define MTB_REG_RANDOM  5'h01
`define MTB_REG_LO0     5'h02
`define MTB_REG_LO1     5'h03
`define MTB_REG_CTX     5'h04
`define MTB_REG_PMASK   5'h05
`define MTB_REG_WIRED   5'h06
`define MTB_REG_EHI     5'h0a
`define MTB_REG_XCTX    5'h14
`define MTB_REG_REGION_CACHE_POLICY    5'h10
// base-bounds registers share numbers 0..3
`define MTB_REG_USER_INSTR_BASE   5'h00
`define MTB_REG_USER_INSTR_LIMIT  5'h01
`define MTB_REG_USER_DATA_BASE   5'h02
`define MTB_REG_USER_DATA_LIMIT  5'h03
// writable bits of the key word, narrow and wide
`define MTB_EHI_N_MASK  64'h00000000ffffffc0
`define MTB_EHI_W_MASK  64'hc00000ffffffe0ff
// page-number and space-identifier compare masks
`define MTB_VPN_N_MASK  64'h00000000fffff000
`define MTB_VPN_W_MASK  64'hc00000ffffffe000
`define MTB_SPACE_IDENTIFIER_N_MASK 64'h0000000000000fc0
`define MTB_SPACE_IDENTIFIER_W_MASK 64'h00000000000000ff
// writable bits of the data words
`define MTB_LO_N_MASK   32'hffffff00
`define MTB_LO_W_MASK   32'h3fffffff
// narrow data word bits
`define MTB_LON_N       11
`define MTB_LON_D       10
`define MTB_LON_V       9
`define MTB_LON_G       8
// wide data word bits
`define MTB_LOW_D       2
`define MTB_LOW_V       1
`define MTB_LOW_G       0
// refill pointers
`define MTB_CTX_SW_MASK  64'h00000000ffe00000
`define MTB_CTX_RD_MASK  64'h00000000fffffffc
`define MTB_XCTX_SW_MASK 64'hfffffffe00000000
// other masks
`define MTB_PMASK_MASK  64'h0000000001ffe000
`define MTB_PAGE_MASK   32'hfffff000
// coherency codes
`define MTB_CC_WT_NOALLOC 3'h0
`define MTB_CC_WT_ALLOC   3'h1
`define MTB_CC_UNCACHED   3'h2
`define MTB_CC_WB         3'h3
// replacement counter bounds
`define MTB_RND_TOP_N   6'h3f
`define MTB_RND_LOW_N   6'h08
`define MTB_RND_TOP_W   6'h2f
`endif

/* verilog/mtb_bb.v */
// base-bounds translator with per-region cache policy
`timescale 1ns/1ps
module mtb_bb (
	input  wire [31:0] va_i,
	input  wire        instr_i,
	input  wire [31:0] user_instr_base_i,
	input  wire [31:0] user_instr_limit_i,
	input  wire [31:0] user_data_base_i,
	input  wire [31:0] user_data_limit_i,
	input  wire [31:0] region_cache_policy_i,
	output wire [31:0] pa_o,
	output wire        err_o,
	output wire [2:0]  coh_o
);
	wire [19:0] base;
	wire [19:0] bound;
	wire [2:0]  region;
	wire [31:0] pol;

	// instruction and data pairs are kept apart
	// separate pairs chosen
	assign base  = instr_i ? user_instr_base_i[31:12] : user_data_base_i[31:12];
	assign bound = instr_i ? user_instr_limit_i[31:12] : user_data_limit_i[31:12];
	assign err_o = (va_i[31:12] > bound);
	assign pa_o  = {va_i[31:12] + base, va_i[11:0]};
	assign region = va_i[31:29];
	assign pol    = region_cache_policy_i >> {region, 2'b00};
	assign coh_o  = pol[2:0];
endmodule // mtb_bb

/* verilog/mtb_mmu.v */
// translation unit: tlb, staging registers and base-bounds mode
// Functional notes
// - base-bounds checks each page number against its space's bound
// - valid base-bounds address gets base added to form physical address
// - two 32-bit base/bound pairs, instruction and data
// - policy register picks caching per 512 Mb region
// - refill pointer high bits writable, low 21 from faulting address
// - refill loads key word page number from failing address
// - space identifier untouched by exceptions
// - tlb read overwrites whole key word including identifier
// - narrow noncacheable bit: 0 cacheable, 1 uncached
// - dirty bit enables stores, clear bit traps stores
// - matching entry with valid clear raises exception
// - narrow global entry matches on page number alone
// - narrow zero fields read zero, writes ignored
// - wide entry maps even/odd pair keyed by page/2
// - wide space identifier is 8 bits
// - wide region field compared with address bits 63:62
// - wide valid clear gives load-miss or store-miss exception
// - wide identifier ignored only when both globals set
// - coherency codes 0,1 write-through variants, 2 uncached
// - random tlb write uses replacement counter slot
// - wired count protects low slots from random writes in wide mode only
// - coherency 3 write-back, 4 to 7 reserved
// - narrow counter resets 63, decrements, wraps from 8 to 63
// - index top bit set when last probe failed
`timescale 1ns/1ps
`include "mtb_defs.vh"
module mtb_mmu #(
	parameter ENTRIES = 64
) (
	input  wire        mclk_i,
	input  wire        rst_n_i,
	input  wire        bb_mode_i,
	input  wire        wide_mode_i,
	input  wire        lk_req_i,
	input  wire [63:0] lk_va_i,
	input  wire        lk_store_i,
	input  wire        lk_instr_i,
	input  wire        cop_wr_i,
	input  wire        cop_rd_i,
	input  wire [4:0]  cop_reg_i,
	input  wire [63:0] cop_wdata_i,
	input  wire        tlb_read_i,
	input  wire        tlb_write_idx_i,
	input  wire        tlb_write_rand_i,
	input  wire        tlb_probe_i,
	output reg         lk_done_o,
	output reg  [35:0] lk_pa_o,
	output reg         lk_uncached_o,
	output reg  [2:0]  lk_coh_o,
	output reg         lk_refill_o,
	output reg         lk_load_miss_o,
	output reg         lk_store_miss_o,
	output reg         lk_write_prot_o,
	output reg         lk_addr_err_o,
	output reg         cop_rvalid_o,
	output reg  [63:0] cop_rdata_o
);
	// entry storage
	reg  [63:0] key_q [0:ENTRIES-1];
	reg  [31:0] lo0_q [0:ENTRIES-1];
	reg  [31:0] lo1_q [0:ENTRIES-1];
	// staging and control registers
	reg  [63:0] ehi_q;
	reg  [31:0] elo0_q;
	reg  [31:0] elo1_q;
	reg  [5:0]  idx_q;
	reg         probe_fail_q;
	reg  [5:0]  rnd_q;
	reg  [5:0]  wired_q;
	reg  [63:0] ctx_q;
	reg  [63:0] xctx_q;
	reg  [63:0] pmask_q;
	reg  [31:0] user_instr_base_q;
	reg  [31:0] user_instr_limit_q;
	reg  [31:0] user_data_base_q;
	reg  [31:0] user_data_limit_q;
	reg  [31:0] region_cache_policy_q;
	reg         rst_s1_q;
	reg         rst_s2_q;
	wire        rst_n;
	// lookup and probe results
	reg         hit;
	reg  [5:0]  hidx;
	reg         phit;
	reg  [5:0]  pidx;
	reg  [31:0] lo_sel;
	reg  [35:0] tlb_pa;
	reg         ent_d;
	reg         ent_v;
	reg  [2:0]  ent_coh;
	reg  [63:0] rd_d;
	reg  [5:0]  rnd_d;
	wire [31:0] bb_pa;
	wire        bb_err;
	wire [2:0]  bb_coh;
	wire [63:0] vmask;
	wire [63:0] amask;
	wire        fault;
	integer     i;
	// key compare shared by lookup and probe
	function match;
		input [63:0] key;
		input [63:0] va;
		input [63:0] cur;
		input        g;
		input [63:0] vm;
		input [63:0] am;
		begin
			match = (((key ^ va) & vm) == 64'h0) && (g || (((key ^ cur) & am) == 64'h0));
		end
	endfunction
	// global flag of one entry for the current variant
	function gbit;
		input        wide;
		input [31:0] l0;
		input [31:0] l1;
		begin
			gbit = wide ? (l0[`MTB_LOW_G] & l1[`MTB_LOW_G]) : l0[`MTB_LON_G];
		end
	endfunction
	// reset release through two flops
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_n = rst_s2_q;
	assign vmask = wide_mode_i ? `MTB_VPN_W_MASK : `MTB_VPN_N_MASK;
	assign amask = wide_mode_i ? `MTB_SPACE_IDENTIFIER_W_MASK : `MTB_SPACE_IDENTIFIER_N_MASK;
	always @* begin
		hit  = 1'b0;
		hidx = 6'h00;
		phit = 1'b0;
		pidx = 6'h00;
		for (i = 0; i < ENTRIES; i = i + 1) begin
			if (!hit && match(key_q[i], lk_va_i, ehi_q,
				gbit(wide_mode_i, lo0_q[i], lo1_q[i]), vmask, amask)) begin
				hit  = 1'b1;
				hidx = i[5:0];
			end
			if (!phit && match(key_q[i], ehi_q, ehi_q,
				gbit(wide_mode_i, lo0_q[i], lo1_q[i]), vmask, amask)) begin
				phit = 1'b1;
				pidx = i[5:0];
			end
		end
	end
	// data word decode for the matching entry
	always @* begin
		lo_sel = (wide_mode_i && lk_va_i[12]) ? lo1_q[hidx] : lo0_q[hidx];
		if (wide_mode_i) begin
			tlb_pa  = {lo_sel[29:6], lk_va_i[11:0]};
			ent_d   = lo_sel[`MTB_LOW_D];
			ent_v   = lo_sel[`MTB_LOW_V];
			ent_coh = lo_sel[5:3];
		end else begin
			tlb_pa  = {4'h0, lo_sel[31:12], lk_va_i[11:0]};
			ent_d   = lo_sel[`MTB_LON_D];
			ent_v   = lo_sel[`MTB_LON_V];
			ent_coh = lo_sel[`MTB_LON_N] ? `MTB_CC_UNCACHED : `MTB_CC_WT_NOALLOC;
		end
	end
	// base-bounds path
	mtb_bb u_bb (
		.va_i     (lk_va_i[31:0]),
		.instr_i  (lk_instr_i),
		.user_instr_base_i  (user_instr_base_q),
		.user_instr_limit_i (user_instr_limit_q),
		.user_data_base_i  (user_data_base_q),
		.user_data_limit_i (user_data_limit_q),
		.region_cache_policy_i   (region_cache_policy_q),
		.pa_o     (bb_pa),
		.err_o    (bb_err),
		.coh_o    (bb_coh)
	);
	assign fault = !hit || !ent_v || (lk_store_i && !ent_d);
	// lookup result flops, faults pulse with done
	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			lk_done_o       <= 1'b0;
			lk_pa_o         <= 36'h0;
			lk_uncached_o   <= 1'b0;
			lk_coh_o        <= 3'h0;
			lk_refill_o     <= 1'b0;
			lk_load_miss_o  <= 1'b0;
			lk_store_miss_o <= 1'b0;
			lk_write_prot_o <= 1'b0;
			lk_addr_err_o   <= 1'b0;
		end else begin
			lk_done_o       <= lk_req_i;
			lk_refill_o     <= 1'b0;
			lk_load_miss_o  <= 1'b0;
			lk_store_miss_o <= 1'b0;
			lk_write_prot_o <= 1'b0;
			lk_addr_err_o   <= 1'b0;
			if (lk_req_i && bb_mode_i) begin
				lk_pa_o       <= bb_err ? 36'h0 : {4'h0, bb_pa};
				lk_addr_err_o <= bb_err;
				lk_coh_o      <= bb_coh;
				lk_uncached_o <= (bb_coh == `MTB_CC_UNCACHED);
			end else if (lk_req_i) begin
				lk_pa_o         <= fault ? 36'h0 : tlb_pa;
				lk_coh_o        <= ent_coh;
				lk_uncached_o   <= (ent_coh == `MTB_CC_UNCACHED) || ent_coh[2];
				lk_refill_o     <= !hit;
				lk_load_miss_o  <= hit && !ent_v && !lk_store_i;
				lk_store_miss_o <= hit && !ent_v && lk_store_i;
				lk_write_prot_o <= hit && ent_v && lk_store_i && !ent_d;
			end
		end
	end
	// replacement counter next value
	always @* begin
		if (cop_wr_i && !bb_mode_i && cop_reg_i == `MTB_REG_WIRED)
			rnd_d = wide_mode_i ? `MTB_RND_TOP_W : `MTB_RND_TOP_N;
		else if (!wide_mode_i && rnd_q <= `MTB_RND_LOW_N)
			rnd_d = `MTB_RND_TOP_N;
		else if (wide_mode_i && (rnd_q <= wired_q || rnd_q > `MTB_RND_TOP_W))
			rnd_d = `MTB_RND_TOP_W;
		else
			rnd_d = rnd_q - 6'h01;
	end
	// entry array writes, no reset on storage
	always @(posedge mclk_i) begin
		if (tlb_write_idx_i || tlb_write_rand_i) begin
			key_q[tlb_write_rand_i ? rnd_q : idx_q] <= ehi_q;
			lo0_q[tlb_write_rand_i ? rnd_q : idx_q] <= elo0_q;
			lo1_q[tlb_write_rand_i ? rnd_q : idx_q] <= elo1_q;
		end
	end
	// staging and control registers
	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			ehi_q        <= 64'h0;
			elo0_q       <= 32'h0;
			elo1_q       <= 32'h0;
			idx_q        <= 6'h00;
			probe_fail_q <= 1'b0;
			rnd_q        <= `MTB_RND_TOP_N;
			wired_q      <= 6'h00;
			ctx_q        <= 64'h0;
			xctx_q       <= 64'h0;
			pmask_q      <= 64'h0;
			user_instr_base_q      <= 32'h0;
			user_instr_limit_q     <= 32'h0;
			user_data_base_q      <= 32'h0;
			user_data_limit_q     <= 32'h0;
			region_cache_policy_q       <= 32'h0;
		end else begin
			rnd_q <= rnd_d;
			// software orders these around unmapped code
			if (cop_wr_i && bb_mode_i) begin
				case (cop_reg_i)
				`MTB_REG_USER_INSTR_BASE:  user_instr_base_q  <= cop_wdata_i[31:0] & `MTB_PAGE_MASK;
				`MTB_REG_USER_INSTR_LIMIT: user_instr_limit_q <= cop_wdata_i[31:0] & `MTB_PAGE_MASK;
				`MTB_REG_USER_DATA_BASE:  user_data_base_q  <= cop_wdata_i[31:0] & `MTB_PAGE_MASK;
				`MTB_REG_USER_DATA_LIMIT: user_data_limit_q <= cop_wdata_i[31:0] & `MTB_PAGE_MASK;
				`MTB_REG_REGION_CACHE_POLICY:   region_cache_policy_q   <= cop_wdata_i[31:0];
				default: ;
				endcase
			end else if (cop_wr_i) begin
				case (cop_reg_i)
				`MTB_REG_INDEX:  idx_q <= wide_mode_i ? cop_wdata_i[5:0] : cop_wdata_i[13:8];
				`MTB_REG_LO0:    elo0_q <= cop_wdata_i[31:0] &
					(wide_mode_i ? `MTB_LO_W_MASK : `MTB_LO_N_MASK);
				`MTB_REG_LO1:    elo1_q <= cop_wdata_i[31:0] & `MTB_LO_W_MASK;
				`MTB_REG_CTX:    ctx_q <= (ctx_q & ~`MTB_CTX_SW_MASK) |
					(cop_wdata_i & `MTB_CTX_SW_MASK);
				`MTB_REG_XCTX:   xctx_q <= (xctx_q & ~`MTB_XCTX_SW_MASK) |
					(cop_wdata_i & `MTB_XCTX_SW_MASK);
				`MTB_REG_PMASK:  pmask_q <= cop_wdata_i & `MTB_PMASK_MASK;
				`MTB_REG_WIRED:  wired_q <= cop_wdata_i[5:0];
				`MTB_REG_EHI:    ehi_q <= cop_wdata_i &
					(wide_mode_i ? `MTB_EHI_W_MASK : `MTB_EHI_N_MASK);
				default: ;
				endcase
			end
			if (tlb_read_i && !bb_mode_i) begin
				ehi_q  <= key_q[idx_q];
				elo0_q <= lo0_q[idx_q];
				elo1_q <= lo1_q[idx_q];
			end
			if (tlb_probe_i && !bb_mode_i) begin
				probe_fail_q <= !phit;
				if (phit)
					idx_q <= pidx;
			end
			if (lk_req_i && !bb_mode_i && fault) begin
				ehi_q <= (ehi_q & amask) | (lk_va_i & vmask);
				// low 21 bits from fault address
				ctx_q[20:2]   <= lk_va_i[30:12];
				xctx_q[32:31] <= lk_va_i[63:62];
				xctx_q[30:4]  <= lk_va_i[39:13];
			end
		end
	end
	// read data selection
	always @* begin
		rd_d = 64'h0;
		if (bb_mode_i) begin
			case (cop_reg_i)
			`MTB_REG_USER_INSTR_BASE:  rd_d = {32'h0, user_instr_base_q};
			`MTB_REG_USER_INSTR_LIMIT: rd_d = {32'h0, user_instr_limit_q};
			`MTB_REG_USER_DATA_BASE:  rd_d = {32'h0, user_data_base_q};
			`MTB_REG_USER_DATA_LIMIT: rd_d = {32'h0, user_data_limit_q};
			`MTB_REG_REGION_CACHE_POLICY:   rd_d = {32'h0, region_cache_policy_q};
			default:         rd_d = 64'h0;
			endcase
		end else begin
			case (cop_reg_i)
			`MTB_REG_INDEX:  rd_d = wide_mode_i ?
				{32'h0, probe_fail_q, 25'h0, idx_q} : {32'h0, probe_fail_q, 17'h0, idx_q, 8'h00};
			`MTB_REG_RANDOM: rd_d = wide_mode_i ?
				{58'h0, rnd_q} : {50'h0, rnd_q, 8'h00};
			`MTB_REG_LO0:    rd_d = {32'h0, elo0_q};
			`MTB_REG_LO1:    rd_d = {32'h0, elo1_q};
			`MTB_REG_CTX:    rd_d = ctx_q & `MTB_CTX_RD_MASK;
			`MTB_REG_XCTX:   rd_d = xctx_q;
			`MTB_REG_PMASK:  rd_d = pmask_q;
			`MTB_REG_WIRED:  rd_d = {58'h0, wired_q};
			`MTB_REG_EHI:    rd_d = ehi_q;
			default:         rd_d = 64'h0;
			endcase
		end
	end
	// registered read port
	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			cop_rvalid_o <= 1'b0;
			cop_rdata_o  <= 64'h0;
		end else begin
			cop_rvalid_o <= cop_rd_i;
			if (cop_rd_i)
				cop_rdata_o <= rd_d;
		end
	end
endmodule // mtb_mmu

/* bench/mtb_core_model.sv */
// core-side model: register moves, tlb operations and lookup requests
`timescale 1ns/1ps
module mtb_core_model (
	input  wire        mclk_i,
	input  wire        bb_i,
	input  wire [63:0] rdata_i,
	output reg         lq_o,
	output reg  [63:0] va_o,
	output reg         st_o,
	output reg         in_o,
	output reg         wr_o,
	output reg         rd_o,
	output reg  [4:0]  rg_o,
	output reg  [63:0] wd_o,
	output reg  [3:0]  op_o
);
	// idle core at time zero
	initial begin
		{lq_o, va_o, st_o, in_o, wr_o, rd_o, rg_o, wd_o, op_o} = 0;
	end
	// one move to a system register
	task wr(input [4:0] r, input [63:0] d);
		@(posedge mclk_i) #5;
		{wr_o, rg_o, wd_o} = {1'b1, r, d};
		@(posedge mclk_i) #5;
		wr_o = 0;
		if (bb_i && r < 5'h04) repeat (5) @(posedge mclk_i);
	endtask
	// read one register, or the same one on two cycles back to back
	task rd(input [4:0] r, input two, output [63:0] a, output [63:0] b);
		@(posedge mclk_i) #5;
		{rd_o, rg_o} = {1'b1, r};
		@(posedge mclk_i) #5;
		a = rdata_i;
		rd_o = two;
		if (two) begin
			@(posedge mclk_i) #5;
			rd_o = 0;
		end
		b = rdata_i;
	endtask
	// tlb operation: 0 read, 1 indexed write, 2 random write, 3 probe
	task op(input [1:0] k);
		@(posedge mclk_i) #5;
		op_o = 4'h1 << k;
		@(posedge mclk_i) #5;
		op_o = 0;
	endtask
	// one lookup request
	task lk(input [63:0] v, input s, input i);
		@(posedge mclk_i) #5;
		{lq_o, va_o, st_o, in_o} = {1'b1, v, s, i};
		@(posedge mclk_i) #5;
		lq_o = 0;
	endtask
endmodule // mtb_core_model

/* bench/mtb_mmu_checker.sv */
// port-level checks for the translation unit
`timescale 1ns/1ps
module mtb_mmu_checker #(
	parameter ENTRIES = 64
) (
	input wire        mclk_i,
	input wire        rst_n_i,
	input wire        bb_mode_i,
	input wire        wide_mode_i,
	input wire        lk_req_i,
	input wire        lk_store_i,
	input wire        cop_rd_i,
	input wire [4:0]  cop_reg_i,
	input wire        lk_done_o,
	input wire [35:0] lk_pa_o,
	input wire        lk_uncached_o,
	input wire [2:0]  lk_coh_o,
	input wire        lk_refill_o,
	input wire        lk_load_miss_o,
	input wire        lk_store_miss_o,
	input wire        lk_write_prot_o,
	input wire        lk_addr_err_o,
	input wire        cop_rvalid_o,
	input wire [63:0] cop_rdata_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	// a lookup taken and answered
	sequence lk_issue;
		lk_req_i ##1 lk_done_o;
	endsequence
	// lookup answer timing and fault flags
	lk_answer_a: assert property (lk_req_i |=> lk_done_o)
		else $error("lookup not answered");
	done_cause_a: assert property (lk_done_o |-> $past(lk_req_i))
		else $error("done without request");
	fault_zero_a: assert property (lk_issue ##0 (lk_addr_err_o || lk_refill_o) |-> lk_pa_o == 0)
		else $error("faulted lookup gave an address");
	load_miss_a: assert property (lk_load_miss_o |-> lk_done_o && !$past(lk_store_i))
		else $error("load miss on a store");
	store_miss_a: assert property (lk_store_miss_o |-> lk_done_o && $past(lk_store_i))
		else $error("store miss on a load");
	write_prot_a: assert property (lk_write_prot_o |-> $past(lk_store_i) && !lk_refill_o)
		else $error("write protect on a load");
	bb_policy_a: assert property (lk_done_o && bb_mode_i |-> lk_uncached_o == (lk_coh_o == 3'h2))
		else $error("uncached disagrees with policy");
	// register read answer and counter range
	read_answer_a: assert property (cop_rd_i |=> cop_rvalid_o)
		else $error("register read not answered");
	rnd_range_a: assert property (cop_rd_i && cop_reg_i == 5'h01 && !bb_mode_i && !wide_mode_i
		|=> cop_rdata_o[13:8] >= 6'h08 && cop_rdata_o[63:14] == 0 && cop_rdata_o[7:0] == 0)
		else $error("replacement counter out of range");
endmodule // mtb_mmu_checker
bind mtb_mmu mtb_mmu_checker #(.ENTRIES(ENTRIES)) mtb_mmu_checker_inst (
	.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bb_mode_i(bb_mode_i), .wide_mode_i(wide_mode_i),
	.lk_req_i(lk_req_i), .lk_store_i(lk_store_i), .cop_rd_i(cop_rd_i), .cop_reg_i(cop_reg_i),
	.lk_done_o(lk_done_o), .lk_pa_o(lk_pa_o), .lk_uncached_o(lk_uncached_o),
	.lk_coh_o(lk_coh_o), .lk_refill_o(lk_refill_o), .lk_load_miss_o(lk_load_miss_o),
	.lk_store_miss_o(lk_store_miss_o), .lk_write_prot_o(lk_write_prot_o),
	.lk_addr_err_o(lk_addr_err_o), .cop_rvalid_o(cop_rvalid_o), .cop_rdata_o(cop_rdata_o)
);

/* bench/mtb_mmu_bench.sv */
// self-checking bench for the translation unit
`timescale 1ns/1ps
module mtb_mmu_bench;
	reg         mclk_i;
	reg         rst_n_i;
	reg         bb_mode_i;
	reg         wide_mode_i;
	reg  [31:0] seed;
	reg  [31:0] bv [0:4];
	reg  [63:0] a;
	reg  [63:0] b;
	integer     fails;
	integer     samples_checked;
	integer     i;
	wire        lq, st, ins, wr, rd, done, unc, rfl, lms, sms, wpr, aer, rvl;
	wire [2:0]  coh;
	wire [3:0]  op;
	wire [4:0]  rg;
	wire [35:0] pa;
	wire [63:0] va, wd, rdat;
	// unit under test and core model
	mtb_mmu mtb_mmu_inst (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bb_mode_i(bb_mode_i), .wide_mode_i(wide_mode_i),
		.lk_req_i(lq), .lk_va_i(va), .lk_store_i(st), .lk_instr_i(ins), .cop_wr_i(wr),
		.cop_rd_i(rd), .cop_reg_i(rg), .cop_wdata_i(wd), .tlb_read_i(op[0]),
		.tlb_write_idx_i(op[1]), .tlb_write_rand_i(op[2]), .tlb_probe_i(op[3]),
		.lk_done_o(done), .lk_pa_o(pa), .lk_uncached_o(unc), .lk_coh_o(coh),
		.lk_refill_o(rfl), .lk_load_miss_o(lms), .lk_store_miss_o(sms),
		.lk_write_prot_o(wpr), .lk_addr_err_o(aer), .cop_rvalid_o(rvl), .cop_rdata_o(rdat)
	);
	mtb_core_model mtb_core_model_inst (
		.mclk_i(mclk_i), .bb_i(bb_mode_i), .rdata_i(rdat), .lq_o(lq), .va_o(va), .st_o(st),
		.in_o(ins), .wr_o(wr), .rd_o(rd), .rg_o(rg), .wd_o(wd), .op_o(op)
	);
	// core clock, 50 ns period
	initial begin
		mclk_i = 0;
		forever #25 mclk_i = ~mclk_i;
	end
	// compare, count and report
	task chk(input [63:0] got, input [63:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task summarize;
		if (fails == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// pseudo-random source and base-bounds expectation
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function [36:0] bb_exp(input [31:0] x, input [31:0] bs, input [31:0] bd);
		bb_exp = (x[31:12] > bd[31:12]) ? {1'b1, 36'h0} : {5'h0, x[31:12] + bs[31:12], x[11:0]};
	endfunction
	// register, tlb and lookup helpers
	task w(input [4:0] r, input [63:0] d);
		mtb_core_model_inst.wr(r, d);
	endtask
	task t(input [1:0] k);
		mtb_core_model_inst.op(k);
	endtask
	task rv(input [4:0] n, input two);
		mtb_core_model_inst.rd(n, two, a, b);
	endtask
	task rc(input [4:0] n, input [63:0] e);
		rv(n, 0);
		chk(a, e);
	endtask
	task ent(input [63:0] k, input [63:0] l0, input [63:0] l1, input [63:0] x);
		w(5'h0a, k);
		w(5'h02, l0);
		w(5'h03, l1);
		w(5'h00, x);
		t(1);
	endtask
	// flags are refill, load miss, store miss, write protect, address error
	task lkc(input [63:0] x, input s, input n, input [4:0] f, input u, input [2:0] c,
		input [35:0] p);
		mtb_core_model_inst.lk(x, s, n);
		chk({done, rfl, lms, sms, wpr, aer}, {1'b1, f});
		if (f == 5'h0) begin
			chk({unc, pa}, {u, p});
			if (wide_mode_i || bb_mode_i) chk(coh, c);
		end else
			chk(pa, 0);
	endtask
	task bbl(input [31:0] x, input n);
		reg [36:0] e;
		reg [2:0]  c;
		e = bb_exp(x, bv[n ? 0 : 2], bv[n ? 1 : 3]);
		c = bv[4][{x[31:29], 2'b00} +: 3];
		lkc({32'h0, x}, seed[1], n, {4'h0, e[36]}, c == 3'h2, c, e[35:0]);
	endtask
	// cut a hung run short
	initial begin
		#5000000;
		fails = fails + 1;
		summarize;
	end
	// main sequence
	initial begin
		fails = 0;
		samples_checked = 0;
		seed = 32'hee4a4ae0;
		rst_n_i = 0;
		bb_mode_i = 0;
		wide_mode_i = 0;
		repeat (16) @(posedge mclk_i);
		#5 rst_n_i = 1;
		repeat (4) @(posedge mclk_i);
		rc(5'h00, 0);
		rc(5'h06, 0);
		// park every slot invalid, then a small narrow table
		for (i = 0; i < 64; i = i + 1)
			ent(64'hfff00000, 0, 0, 64'({i[5:0], 8'h00}));
		ent(64'h123450c0, 64'habcdea00, 0, 64'h500);
		ent(64'h22222000, 64'h55555700, 0, 64'h600);
		ent(64'h333330c0, 64'h77777400, 0, 64'h700);
		lkc(64'h12345678, 0, 0, 5'h00, 1, 0, 36'habcde678);
		lkc(64'h12345678, 1, 0, 5'h02, 0, 0, 0);
		lkc(64'h22222abc, 1, 0, 5'h00, 0, 0, 36'h55555abc);
		lkc(64'h33333000, 0, 0, 5'h08, 0, 0, 0);
		lkc(64'h33333000, 1, 0, 5'h04, 0, 0, 0);
		w(5'h04, 64'hffffffff);
		lkc(64'h44445000, 0, 0, 5'h10, 0, 0, 0);
		rc(5'h0a, 64'h444450c0);
		rc(5'h04, 64'hfff11114);
		// identifier mismatch, probe, tlb read and zero fields
		w(5'h0a, 64'h12345100);
		lkc(64'h12345678, 0, 0, 5'h10, 0, 0, 0);
		t(3);
		rv(5'h00, 0);
		chk(a[31], 1);
		w(5'h0a, 64'h123450c0);
		t(3);
		rc(5'h00, 64'h500);
		w(5'h0a, 0);
		t(0);
		rc(5'h0a, 64'h123450c0);
		rc(5'h02, 64'habcdea00);
		w(5'h02, 64'hffffffff);
		rc(5'h02, 64'hffffff00);
		w(5'h0a, 64'hffffffffffffffff);
		rc(5'h0a, 64'hffffffc0);
		// counter steps and random-slot write
		rv(5'h01, 1);
		chk(b[13:8], (a[13:8] == 6'h08) ? 6'h3f : a[13:8] - 6'h01);
		w(5'h0a, 64'h66666000);
		w(5'h02, 64'h11111600);
		t(2);
		t(3);
		rv(5'h00, 0);
		chk({a[31], a[13:8] >= 6'h08}, 2'b01);
		lkc(64'h66666abc, 0, 0, 5'h00, 0, 0, 36'h11111abc);
		// wide pair entry
		wide_mode_i = 1;
		ent(64'hc0000002468ac005, 64'h2af379f, 64'h3fb72d6, 64'h9);
		lkc(64'hc0000002468ac123, 0, 0, 5'h00, 0, 3'h3, 36'h0abcde123);
		lkc(64'hc0000002468ad123, 1, 0, 5'h00, 1, 3'h2, 36'h0fedcb123);
		w(5'h0a, 64'hc0000002468ac085);
		lkc(64'hc0000002468ac123, 0, 0, 5'h10, 0, 0, 0);
		w(5'h0a, 64'hc0000002468ac005);
		lkc(64'h40000002468ac123, 0, 0, 5'h10, 0, 0, 0);
		// wide refill pointer: region and page pair of the last fault, then base bits
		rc(5'h14, 64'h81234560);
		w(5'h14, 64'hffffffffffffffff);
		rc(5'h14, 64'hfffffffe81234560);
		// page size mask keeps only its mask field
		w(5'h05, 64'hffffffffffffffff);
		rc(5'h05, 64'h1ffe000);
		w(5'h06, 64'h4);
		rc(5'h06, 64'h4);
		rv(5'h01, 0);
		chk(a[5:0] >= 6'h04 && a[5:0] <= 6'h2f, 1);
		// base-bounds with random pairs and policy
		wide_mode_i = 0;
		bb_mode_i = 1;
		for (i = 0; i < 5; i = i + 1) begin
			seed = lfsr(seed);
			bv[i] = seed & ((i == 4) ? 32'hffffffff : i[0] ? 32'h7fffffff : 32'h0ffff000);
			w((i == 4) ? 5'h10 : i[4:0], {32'h0, bv[i]});
			if (i < 4) rc(i[4:0], {32'h0, bv[i] & 32'hfffff000});
		end
		for (i = 0; i < 40; i = i + 1) begin
			seed = lfsr(seed);
			bbl(seed & 32'h7fffffff, seed[0]);
		end
		bbl(bv[1] | 32'hfff, 1);
		bbl(bv[3] + 32'h1000, 0);
		summarize;
	end
endmodule // mtb_mmu_bench
